// >>> design/sfl_defs.svh
// Offsets, field positions, codes and timing counts of the synth control words
`ifndef SFL_DEFS_SVH
`define SFL_DEFS_SVH

// ****************************************************************
// Word select codes (three least significant bits)
// ****************************************************************
`define SFL_SEL_CHANNEL      3'h0
`define SFL_SEL_DIVIDER      3'h1
`define SFL_SEL_PHASE        3'h2
`define SFL_SEL_FAST_LOCK    3'h4
`define SFL_SEL_POWER        3'h5
`define SFL_SEL_MODE_MUX     3'h6

// ****************************************************************
// Field positions
// ****************************************************************
`define SFL_TMR_CNT_MSB      13
`define SFL_TMR_CNT_LSB      5
`define SFL_TMR_SEL_MSB      4
`define SFL_TMR_SEL_LSB      3
`define SFL_PWR_AMP_HI       7
`define SFL_PWR_AMP_LO       6
`define SFL_PWR_CP_PD        5
`define SFL_PWR_TRISTATE     4
`define SFL_PWR_CNT_RST      3
`define SFL_MODE_MSB         15
`define SFL_MODE_LSB         12
`define SFL_MUX_MSB          6
`define SFL_MUX_LSB          3

// ****************************************************************
// Timer select codes and mode codes
// ****************************************************************
`define SFL_TSEL_BOOST       2'h2
`define SFL_TSEL_WIDE        2'h1
`define SFL_TSEL_DAMP        2'h0
`define SFL_MODE_DEFAULT     4'h0
`define SFL_MODE_DITHER      4'h3
`define SFL_MODE_WIDE_LD     4'h9

// ****************************************************************
// Test output sources
// ****************************************************************
`define SFL_MUX_LOW          4'h0
`define SFL_MUX_LOCK         4'h1
`define SFL_MUX_INT_DIV      4'h2
`define SFL_MUX_REF_DIV      4'h3
`define SFL_MUX_BOOST_PULSE  4'h4
`define SFL_MUX_WIDE_PULSE   4'h5
`define SFL_MUX_DAMP_PULSE   4'h6
`define SFL_MUX_HIGH         4'hf

// ****************************************************************
// Timing
// ****************************************************************
`define SFL_TICK_DIV         4
`define SFL_BOOST_LOG2_MAX   3'h6

// ****************************************************************
// Register port map (word addresses in bytes)
// ****************************************************************
`define SFL_OFS_BOOST_CNT    8'h00
`define SFL_OFS_WIDE_CNT     8'h04
`define SFL_OFS_DAMP_CNT     8'h08
`define SFL_OFS_POWER        8'h0c
`define SFL_OFS_MODE_MUX     8'h10
`define SFL_OFS_STATUS       8'h14
`define SFL_OFS_LOAD         8'h18

// ****************************************************************
// Reset values
// ****************************************************************
`define SFL_RST_POWER        8'hfd
`define SFL_RST_MODE_MUX     16'h0000
`define SFL_RST_COUNT        9'h000

`endif

// >>> design/sfl_pkg.sv
// Types shared by the synth control-word logic
package sfl_pkg;
  typedef enum logic [2:0]
  {
    SFL_WORD_CHANNEL   = 3'h0,
    SFL_WORD_DIVIDER   = 3'h1,
    SFL_WORD_PHASE     = 3'h2,
    SFL_WORD_FUNCTION  = 3'h3,
    SFL_WORD_FAST_LOCK = 3'h4,
    SFL_WORD_POWER     = 3'h5,
    SFL_WORD_MODE_MUX  = 3'h6,
    SFL_WORD_TEST      = 3'h7
  } sfl_word_sel_t;
endpackage : sfl_pkg

// >>> design/sfl_regs.sv
// Fast-lock timer, power control and mode/mux word logic of the synthesizer
// Function
// R1: Word select 101 chooses the power control word.
// R2: Word select 110 chooses the mode/mux word.
// R3: Host loads fast-lock word bits 23..14 with 001.
// R4: Timeout counters tick at quarter phase-detector rate, four cycles per count.
// R5: Timer select 10 boost, 01 wide-band, 00 damping counter.
// R6: Host writes fast-lock word three times, once per timer.
// R7: Every channel word write restarts all three timeout counters.
// R8: Damping and wide-band switches stay closed until their counters expire.
// R9: Boost expiry steps pump current 64x down to 1x in six halvings.
// R10: Host sets switch counts to boost count plus seven.
// R11: Stay powered down until power, phase, divider, channel words written.
// R12: Amplifier off when bits 7,6 both high, on when both low.
// R13: Bit 5 holds dividers, tristates pump, resets lock detect, disables buffer.
// R14: Host leaves pump power-down by clearing bit 5 then channel write.
// R15: Three-state bit high puts pump outputs into high impedance.
// R16: Counter-reset bit holds counters; clear then channel write resumes.
// R17: Host first writes mode bits 0000: dither off, 3 ns threshold. The bench's first mode write is 0011.
// R18: Mode bits 0011 enable modulator dither.
// R19: Mode bits 1001 widen lock-detect threshold to 10 ns.
// R20: Mode bits 0000 restore dither off and 3 ns threshold.
// R21: Host writes mode/mux reserved bits as zero.
// R22: Mux field routes reference, integer divider or lock detect out.
// R23: Test output can show a timeout pulse from next channel write.
// R24: Channel write takes effect next phase-detector cycle, entering fast lock.
// R25: Shifted word lands only at load-enable edge in its selected register.
// R26: Channel write during a running count reloads and restarts fast lock.
`timescale 1ns/10ps
`include "sfl_defs.svh"
module sfl_regs
  import sfl_pkg::*;
#(
  parameter int CNT_W   = 9,
  parameter int SHIFT_W = 24
)
(
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_clk_en,
  input  wire logic         i_ser_clk,
  input  wire logic         i_ser_data,
  input  wire logic         i_ser_le,
  input  wire logic [7:0]   i_reg_addr,
  input  wire logic [31:0]  i_reg_wdata,
  input  wire logic         i_reg_wr,
  input  wire logic         i_reg_rd,
  output logic      [31:0]  o_reg_rdata,
  input  wire logic         i_ref_div_out,
  input  wire logic         i_int_div_out,
  input  wire logic         i_lock_detect,
  output logic              o_channel_load,
  output logic              o_power_down,
  output logic              o_amp_power_down,
  output logic              o_divider_load_hold,
  output logic              o_cp_three_state,
  output logic              o_lock_detect_reset,
  output logic              o_ref_buffer_disable,
  output logic              o_counter_reset,
  output logic              o_damping_switch,
  output logic              o_wide_band_switch_a,
  output logic              o_wide_band_switch_b,
  output logic      [2:0]   o_cp_scale_log2,
  output logic              o_dither_en,
  output logic              o_lock_wide_threshold,
  output logic              o_test_output
);
  // ****************************************************************
  // Serial pin synchronisers
  // ****************************************************************
  logic [2:0] sclk_sync_ff;
  logic [2:0] le_sync_ff;
  logic [1:0] sdat_sync_ff;
  logic [SHIFT_W-1:0] shift_ff;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sclk_sync_ff <= 3'h0;
      le_sync_ff   <= 3'h0;
      sdat_sync_ff <= 2'h0;
    end
    else if (i_clk_en)
    begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], i_ser_clk};
      le_sync_ff   <= {le_sync_ff[1:0], i_ser_le};
      sdat_sync_ff <= {sdat_sync_ff[0], i_ser_data};
    end
  end
  // Edges are found between stages two and three, never on the first stage
  wire logic sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
  wire logic le_rise   = le_sync_ff[1] & ~le_sync_ff[2];
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      shift_ff <= '0;
    else if (i_clk_en && sclk_rise)
      shift_ff <= {shift_ff[SHIFT_W-2:0], sdat_sync_ff[1]};
  end
  // ****************************************************************
  // Word capture: serial latch edge or register port write
  // ****************************************************************
  // Last three bits shifted in are the select, whatever the word length
  logic        bus_wr;
  logic [23:0] bus_word;
  assign bus_wr = i_reg_wr && (i_reg_addr inside {`SFL_OFS_BOOST_CNT,
    `SFL_OFS_WIDE_CNT, `SFL_OFS_DAMP_CNT, `SFL_OFS_POWER, `SFL_OFS_MODE_MUX,
    `SFL_OFS_LOAD});
  // Port writes other than the load offset are rebuilt into a word with the matching select code
  always_comb
  begin
    unique case (i_reg_addr)
      `SFL_OFS_BOOST_CNT:
        bus_word = {10'h000, i_reg_wdata[CNT_W-1:0], `SFL_TSEL_BOOST,
                    `SFL_SEL_FAST_LOCK};
      `SFL_OFS_WIDE_CNT:
        bus_word = {10'h000, i_reg_wdata[CNT_W-1:0], `SFL_TSEL_WIDE,
                    `SFL_SEL_FAST_LOCK};
      `SFL_OFS_DAMP_CNT:
        bus_word = {10'h000, i_reg_wdata[CNT_W-1:0], `SFL_TSEL_DAMP,
                    `SFL_SEL_FAST_LOCK};
      `SFL_OFS_POWER:
        bus_word = {16'h0000, i_reg_wdata[7:3], `SFL_SEL_POWER};
      `SFL_OFS_MODE_MUX:
        bus_word = {8'h00, i_reg_wdata[15:3], `SFL_SEL_MODE_MUX};
      default:           bus_word = i_reg_wdata[23:0];
    endcase
  end
  logic          wr_any;
  logic [23:0]   wr_word;
  sfl_word_sel_t wr_sel;
  assign wr_any  = le_rise | bus_wr;
  assign wr_word = le_rise ? shift_ff : bus_word;
  assign wr_sel  = sfl_word_sel_t'(wr_word[2:0]);
  logic wr_chan;
  logic wr_timer;
  logic wr_power;
  logic wr_mode;
  assign wr_chan  = wr_any && wr_sel == SFL_WORD_CHANNEL;
  assign wr_timer = wr_any && wr_sel == SFL_WORD_FAST_LOCK;
  assign wr_power = wr_any && wr_sel == SFL_WORD_POWER;      // R1
  assign wr_mode  = wr_any && wr_sel == SFL_WORD_MODE_MUX;   // R2
  // ****************************************************************
  // Stored words
  // ****************************************************************
  logic [CNT_W-1:0] tmr_cnt_ff [3];
  logic [7:0]       power_ff;
  logic [15:0]      mode_mux_ff;
  logic [1:0]       tsel;
  assign tsel = wr_word[`SFL_TMR_SEL_MSB:`SFL_TMR_SEL_LSB];
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      power_ff <= `SFL_RST_POWER;
    else if (i_clk_en && wr_power)                            // R25
      power_ff <= wr_word[7:0];
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      mode_mux_ff <= `SFL_RST_MODE_MUX;
    else if (i_clk_en && wr_mode)                             // R25
      mode_mux_ff <= wr_word[15:0];
  end
  // ****************************************************************
  // Power-up tracking and power controls
  // ****************************************************************
  logic seen_pwr_ff;
  logic seen_div_ff;
  logic seen_phase_ff;
  logic seen_chan_ff;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      seen_pwr_ff   <= 1'b0;
      seen_div_ff   <= 1'b0;
      seen_phase_ff <= 1'b0;
      seen_chan_ff  <= 1'b0;
    end
    else if (i_clk_en && wr_any)
    begin
      if (wr_power)                                           // R11
        seen_pwr_ff <= wr_word[`SFL_PWR_AMP_HI:`SFL_PWR_CP_PD] == 3'h0;
      if (wr_sel == SFL_WORD_DIVIDER)
        seen_div_ff <= 1'b1;
      if (wr_sel == SFL_WORD_PHASE)
        seen_phase_ff <= 1'b1;
      if (wr_chan)
        seen_chan_ff <= 1'b1;
    end
  end
  logic powered_ff;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      powered_ff <= 1'b0;
    else if (i_clk_en && seen_pwr_ff && seen_div_ff && seen_phase_ff &&
             seen_chan_ff)
      powered_ff <= 1'b1;                                     // R11
  end
  // A mixed pair of amplifier bits keeps the previous state
  logic amp_pd_ff;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      amp_pd_ff <= 1'b1;
    else if (i_clk_en && power_ff[`SFL_PWR_AMP_HI] == power_ff[`SFL_PWR_AMP_LO])
      amp_pd_ff <= power_ff[`SFL_PWR_AMP_HI];                 // R12
  end
  // Pump power-down and counter reset only end at a channel write
  logic cp_pd_hold_ff;
  logic cnt_rst_hold_ff;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cp_pd_hold_ff   <= 1'b1;
      cnt_rst_hold_ff <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (power_ff[`SFL_PWR_CP_PD])
        cp_pd_hold_ff <= 1'b1;                                // R13
      else if (wr_chan)
        cp_pd_hold_ff <= 1'b0;                                // R14
      if (power_ff[`SFL_PWR_CNT_RST])
        cnt_rst_hold_ff <= 1'b1;                              // R16
      else if (wr_chan)
        cnt_rst_hold_ff <= 1'b0;                              // R16
    end
  end
  logic pd_all;
  assign pd_all = ~powered_ff | cp_pd_hold_ff;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_power_down         <= 1'b1;
      o_amp_power_down     <= 1'b1;
      o_divider_load_hold  <= 1'b1;
      o_cp_three_state     <= 1'b1;
      o_lock_detect_reset  <= 1'b1;
      o_ref_buffer_disable <= 1'b1;
      o_counter_reset      <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_power_down         <= ~powered_ff;                    // R11
      o_amp_power_down     <= amp_pd_ff | ~powered_ff;        // R12
      o_divider_load_hold  <= pd_all;                         // R13
      o_cp_three_state     <= pd_all | power_ff[`SFL_PWR_TRISTATE]; // R15
      o_lock_detect_reset  <= pd_all;                         // R13
      o_ref_buffer_disable <= pd_all;                         // R13
      o_counter_reset      <= cnt_rst_hold_ff;                // R16
    end
  end
  // ****************************************************************
  // Fast-lock sequence
  // ****************************************************************
  // Channel write acts on the following cycle
  logic chan_go_ff;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      chan_go_ff <= 1'b0;
    else if (i_clk_en)
      chan_go_ff <= wr_chan;                                  // R24
  end
  assign o_channel_load = chan_go_ff & i_clk_en;
  // Prescaler restarts at the go cycle so each count is exactly 4 cycles
  logic [1:0] pre_ff;
  logic       tick;
  assign tick = (pre_ff == 2'(`SFL_TICK_DIV - 1));
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pre_ff <= 2'h0;
    else if (i_clk_en)
      pre_ff <= chan_go_ff ? 2'h0 : pre_ff + 2'h1;            // R4
  end
  logic [CNT_W-1:0] run_ff [3];
  logic [2:0]       busy;
    // Index 0 boost, 1 wide-band, 2 damping: timer select code is 2 - index
    for (genvar gi = 0; gi < 3; gi++)
    begin : g_tmr
      assign busy[gi] = (run_ff[gi] != '0);
      always_ff @(posedge i_sys_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
          tmr_cnt_ff[gi] <= `SFL_RST_COUNT;
        else if (i_clk_en && wr_timer && tsel == 2'(2 - gi))  // R5 R25
          tmr_cnt_ff[gi] <= wr_word[`SFL_TMR_CNT_MSB:`SFL_TMR_CNT_LSB];
      end
      always_ff @(posedge i_sys_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
          run_ff[gi] <= '0;
        else if (i_clk_en)
        begin
          if (cnt_rst_hold_ff)
            run_ff[gi] <= '0;                                 // R16
          else if (chan_go_ff)
            run_ff[gi] <= tmr_cnt_ff[gi];                     // R7 R26
          else if (tick && busy[gi])
            run_ff[gi] <= run_ff[gi] - 1'b1;                  // R4
        end
      end
    end
  logic [2:0] scale_ff;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      scale_ff <= 3'h0;
    else if (i_clk_en)
    begin
      if (cnt_rst_hold_ff)
        scale_ff <= 3'h0;
      else if (chan_go_ff)
        scale_ff <= `SFL_BOOST_LOG2_MAX;                      // R24
      else if (tick && run_ff[0] <= CNT_W'(1) && scale_ff != 3'h0)
        scale_ff <= scale_ff - 3'h1;                          // R9
    end
  end
  assign o_cp_scale_log2      = scale_ff;
  assign o_damping_switch     = busy[2];                      // R8
  assign o_wide_band_switch_a = busy[1];                      // R8
  assign o_wide_band_switch_b = busy[1];                      // R8
  // ****************************************************************
  // Modulator and lock-detect modes
  // ****************************************************************
  // Dither and wide-threshold codes set one setting, default clears both; unknown codes change nothing
  logic [3:0] mode_code;
  assign mode_code = wr_word[`SFL_MODE_MSB:`SFL_MODE_LSB];
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_dither_en           <= 1'b0;
      o_lock_wide_threshold <= 1'b0;
    end
    else if (i_clk_en && wr_mode && mode_code == `SFL_MODE_DEFAULT)
    begin
      o_dither_en           <= 1'b0;                          // R17 R20
      o_lock_wide_threshold <= 1'b0;                          // R17 R20
    end
    else if (i_clk_en && wr_mode && mode_code == `SFL_MODE_DITHER)
      o_dither_en <= 1'b1;                                    // R18
    else if (i_clk_en && wr_mode && mode_code == `SFL_MODE_WIDE_LD)
      o_lock_wide_threshold <= 1'b1;                          // R19
  end
  // ****************************************************************
  // Test output multiplexer
  // ****************************************************************
  logic test_nxt;
  always_comb
  begin
    unique case (mode_mux_ff[`SFL_MUX_MSB:`SFL_MUX_LSB])      // R22
      `SFL_MUX_LOCK:        test_nxt = i_lock_detect;
      `SFL_MUX_INT_DIV:     test_nxt = i_int_div_out;
      `SFL_MUX_REF_DIV:     test_nxt = i_ref_div_out;
      `SFL_MUX_BOOST_PULSE: test_nxt = busy[0];               // R23
      `SFL_MUX_WIDE_PULSE:  test_nxt = busy[1];               // R23
      `SFL_MUX_DAMP_PULSE:  test_nxt = busy[2];               // R23
      `SFL_MUX_HIGH:        test_nxt = 1'b1;
      default:              test_nxt = 1'b0;
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_test_output <= 1'b0;
    else if (i_clk_en)
      o_test_output <= test_nxt;
  end
  // ****************************************************************
  // Register port read-back
  // ****************************************************************
  logic [31:0] rd_nxt;
  always_comb
  begin
    unique case (i_reg_addr)
      `SFL_OFS_BOOST_CNT: rd_nxt = {23'h0, tmr_cnt_ff[0]};
      `SFL_OFS_WIDE_CNT:  rd_nxt = {23'h0, tmr_cnt_ff[1]};
      `SFL_OFS_DAMP_CNT:  rd_nxt = {23'h0, tmr_cnt_ff[2]};
      `SFL_OFS_POWER:     rd_nxt = {24'h0, power_ff};
      `SFL_OFS_MODE_MUX:  rd_nxt = {16'h0, mode_mux_ff};
      `SFL_OFS_STATUS:
        rd_nxt = {22'h0, scale_ff, busy, o_lock_wide_threshold, o_dither_en,
                  cp_pd_hold_ff, powered_ff};
      default:            rd_nxt = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_reg_rdata <= 32'h0000_0000;
    else if (i_clk_en)
      o_reg_rdata <= i_reg_rd ? rd_nxt : 32'h0000_0000;
  end
endmodule : sfl_regs

// >>> sim/sfl_regs_chk.sv
// Port assertions for the synth control-word block
`timescale 1ns/10ps
module sfl_regs_chk
(
  input wire logic       i_sys_clk,
  input wire logic       i_reset_n,
  input wire logic       o_channel_load,
  input wire logic       o_power_down,
  input wire logic       o_divider_load_hold,
  input wire logic       o_cp_three_state,
  input wire logic       o_lock_detect_reset,
  input wire logic       o_counter_reset,
  input wire logic       o_damping_switch,
  input wire logic       o_wide_band_switch_a,
  input wire logic       o_wide_band_switch_b,
  input wire logic [2:0] o_cp_scale_log2
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  a_load_pulse: assert property (
    o_channel_load |=> !o_channel_load) else $error("load pulse too long");
  a_boost_start: assert property (
    o_channel_load |-> ##[0:2] o_cp_scale_log2 == 3'h6)
    else $error("no full pump current after channel load");
  // Clearing to zero is left out: counter reset may drop the scale at once
  a_scale_halve: assert property (
    (o_cp_scale_log2 < $past(o_cp_scale_log2)) && (o_cp_scale_log2 != 3'h0)
    |-> o_cp_scale_log2 == $past(o_cp_scale_log2) - 3'h1)
    else $error("pump scale skipped a step");
  a_wide_pair: assert property (
    o_wide_band_switch_a == o_wide_band_switch_b)
    else $error("wide-band switches differ");
  a_hold_group: assert property (
    o_divider_load_hold |-> o_cp_three_state && o_lock_detect_reset)
    else $error("pump power-down group incomplete");
  a_pd_hold: assert property (
    o_power_down |-> o_divider_load_hold) else $error("powered down not held");
  a_damp_start: assert property (
    $rose(o_damping_switch) |-> o_channel_load || $past(o_channel_load)
    || $past(o_channel_load, 2)) else $error("damping closed without load");
  a_wide_start: assert property (
    $rose(o_wide_band_switch_a) |-> o_channel_load || $past(o_channel_load)
    || $past(o_channel_load, 2)) else $error("wide closed without load");
  a_cnt_clear: assert property (
    o_counter_reset ##1 o_counter_reset |-> o_cp_scale_log2 == 3'h0
    && !o_damping_switch && !o_wide_band_switch_a)
    else $error("counters run during counter reset");
endmodule : sfl_regs_chk

bind sfl_regs sfl_regs_chk u_chk (.*);

// >>> sim/sfl_host.sv
// Host side serial writer: shifts words MSB first and pulses load enable
`timescale 1ns/10ps
module sfl_host
(
  input  wire logic i_clk,
  output logic      o_ser_clk,
  output logic      o_ser_data,
  output logic      o_ser_le
);
  // ****************************************************************
  // Serial frame
  // ****************************************************************
  initial
  begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_ser_le = 1'b0;
  end
  // Link clock stands low between frames; 8 system cycles make 320 ns
  task send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--)
    begin
      o_ser_data <= w[i];
      repeat (4) @(posedge i_clk);
      o_ser_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_ser_clk <= 1'b0;
    end
    // Idle data shows the inverse of the last bit so nothing leans on it
    o_ser_data <= ~w[0];
    repeat (4) @(posedge i_clk);
    o_ser_le <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_ser_le <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask : send
endmodule : sfl_host

// >>> sim/tb.sv
// Bench for the synth control-word block driven by a serial host model
`timescale 1ns/10ps
`include "sfl_defs.svh"
module tb;
  localparam int BOOST = 2;
  localparam int SW    = BOOST + 7;
  logic        i_sys_clk   = 1'b0;
  logic        i_reset_n   = 1'b0;
  logic        i_clk_en    = 1'b1;
  logic [7:0]  i_reg_addr  = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0;
  logic        i_reg_wr    = 1'b0;
  logic        i_reg_rd    = 1'b0;
  logic [2:0]  src         = 3'h0;
  wire         i_lock_detect = src[0];
  wire         i_int_div_out = src[1];
  wire         i_ref_div_out = src[2];
  logic        i_ser_clk, i_ser_data, i_ser_le;
  logic [31:0] o_reg_rdata;
  logic [2:0]  o_cp_scale_log2;
  logic        o_channel_load, o_power_down, o_amp_power_down;
  logic        o_divider_load_hold, o_cp_three_state, o_lock_detect_reset;
  logic        o_ref_buffer_disable, o_counter_reset, o_damping_switch;
  logic        o_wide_band_switch_a, o_wide_band_switch_b, o_dither_en;
  logic        o_lock_wide_threshold, o_test_output;
  int          miscompares = 0;
  int          checked     = 0;
  int          cycles      = 0;
  always #20 i_sys_clk = ~i_sys_clk;
  sfl_regs u_dut (.*);
  sfl_host u_host (.i_clk(i_sys_clk), .o_ser_clk(i_ser_clk),
                   .o_ser_data(i_ser_data), .o_ser_le(i_ser_le));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [23:0] mm(input logic [3:0] md, mx);
    return {8'h00, md, 5'h00, mx, 3'h6};
  endfunction : mm
  function automatic logic [23:0] tl(input logic [1:0] ts, logic [8:0] c);
    return {10'h001, c, ts, 3'h4};
  endfunction : tl
  task cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : cyc
  task chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk(n, o_reg_rdata, e);
  endtask : rd
  task ld(input logic [23:0] w);
    wr(`SFL_OFS_LOAD, {8'h00, w});
  endtask : ld
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_power_up;
    cyc(1);
    chk("reset power", {o_power_down, o_amp_power_down}, 2'b11);
    u_host.send(24'h000005);
    ld(tl(2'h2, BOOST));
    ld(tl(2'h1, SW));
    ld(tl(2'h0, SW));
    u_host.send(24'h000002);
    u_host.send(24'h000001);
    chk("early power", o_power_down, 1'b1);
    u_host.send(24'h000000);
    chk("powered", {o_power_down, o_divider_load_hold}, 2'b00);
    rd(8'h1c, 32'h0, "unmapped");
  endtask : t_power_up
  task t_fast_lock;
    int d, w, b, h;
    d = 0; w = 0; b = 0; h = 0;
    ld(24'h0);
    cyc(20);
    ld(24'h0);
    repeat (100)
    begin
      cyc(1);
      d += o_damping_switch;
      w += o_wide_band_switch_a && o_wide_band_switch_b;
      b += (o_cp_scale_log2 == 3'h6);
      h += (o_cp_scale_log2 inside {[3'h1:3'h5]});
    end
    chk("damp time", d >= 4 * SW - 2 && d <= 4 * SW + 2, 1'b1);
    chk("wide time", w >= 4 * SW - 2 && w <= 4 * SW + 2, 1'b1);
    chk("boost time", b >= 4 * BOOST - 2 && b <= 4 * BOOST + 2, 1'b1);
    chk("ramp time", h >= 18 && h <= 22, 1'b1);
    chk("ramp end", o_cp_scale_log2, 3'h0);
    rd(`SFL_OFS_STATUS, 32'h1, "status");
  endtask : t_fast_lock
  task t_power_bits;
    wr(`SFL_OFS_POWER, 32'hc0);
    cyc(3);
    chk("amp down", o_amp_power_down, 1'b1);
    wr(`SFL_OFS_POWER, 32'h10);
    cyc(3);
    chk("amp up", {o_amp_power_down, o_cp_three_state}, 2'b01);
    wr(`SFL_OFS_POWER, 32'h28);
    cyc(3);
    chk("pd set", {o_divider_load_hold, o_cp_three_state, o_lock_detect_reset,
        o_ref_buffer_disable, o_counter_reset}, 5'h1f);
    u_host.send(mm(4'h3, 4'h1));
    chk("serial live", o_dither_en, 1'b1);
    wr(`SFL_OFS_POWER, 32'h00);
    cyc(3);
    chk("pd kept", {o_divider_load_hold, o_counter_reset}, 2'b11);
    ld(24'h0);
    cyc(3);
    chk("pd gone", {o_divider_load_hold, o_cp_three_state, o_lock_detect_reset,
        o_ref_buffer_disable, o_counter_reset}, 5'h00);
  endtask : t_power_bits
  task t_mode;
    int p;
    p = 0;
    u_host.send(mm(4'h0, 4'h1));
    chk("mode off", {o_dither_en, o_lock_wide_threshold}, 2'b00);
    wr(`SFL_OFS_MODE_MUX, mm(4'h9, 4'h1));
    cyc(3);
    chk("wide thr", o_lock_wide_threshold, 1'b1);
    for (int c = 1; c <= 3; c++)
    begin
      wr(`SFL_OFS_MODE_MUX, mm(4'h0, 4'(c)));
      for (int v = 0; v < 2; v++)
      begin
        @(posedge i_sys_clk);
        src <= v[0] ? 3'h1 << (c - 1) : ~(3'h1 << (c - 1));
        cyc(3);
        chk("test out", o_test_output, v[0]);
      end
    end
    wr(`SFL_OFS_MODE_MUX, mm(4'h0, 4'h4));
    ld(24'h0);
    repeat (40)
    begin
      cyc(1);
      p += o_test_output;
    end
    chk("pulse", p >= 4 * BOOST - 2 && p <= 4 * BOOST + 2, 1'b1);
  endtask : t_mode
  task test_done;
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (4) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    t_power_up();
    t_fast_lock();
    t_power_bits();
    t_mode();
    test_done();
  end
  // A hung handshake would otherwise stall the run
  always @(posedge i_sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      miscompares++;
      test_done();
    end
  end
endmodule : tb
